//--- dtsm_defs.svh
// Constants for the debug trace address and map-space decode block.
// Assumes inclusion by bare name from the block's design files.
//
// What this block does
// - Trace messages carry only low 25 address bits
// - Range registers hold 25-bit start and end
// - Range match compares low 25 bits only
// - Map bit set selects register space
// - Decrementer and timebase at fixed internal addresses
// - Global region attribute registers at 0x2100/0x3100
// - Exception relocation base at 0x2300
// - Burst buffer, bridge configs at 0x2110/0x3110
// - Devport data 0x2d30, memory map 0x3d30
// - Ifetch region bases at 0x2180 step 0x200
// - Bridge region bases at 0x3180 step 0x200
// - Ifetch region attributes at 0x2190 step 0x200
// - Bridge region attributes at 0x3190 step 0x200
// - Other core registers only via devport messages
// - Core-resident register numbers refused in map space
// - Access request carries only 25 address bits
// - Devport messages use codes 56 and 57
`ifndef DTSM_DEFS_SVH
`define DTSM_DEFS_SVH
`define DTSM_ADDR_W        25
`define DTSM_MAP_W         14
`define DTSM_DEC_ADDR      14'h2c00
`define DTSM_TBL_RD_ADDR   14'h1880
`define DTSM_TBH_RD_ADDR   14'h1a80
`define DTSM_TBL_WR_ADDR   14'h3880
`define DTSM_TBH_WR_ADDR   14'h3a80
`define DTSM_IF_GRA_ADDR   14'h2100
`define DTSM_BR_GRA_ADDR   14'h3100
`define DTSM_EXC_ADDR      14'h2300
`define DTSM_BB_CFG_ADDR   14'h2110
`define DTSM_BR_CFG_ADDR   14'h3110
`define DTSM_DPD_ADDR      14'h2d30
`define DTSM_IMM_ADDR      14'h3d30
`define DTSM_IF_RBA_BASE   14'h2180
`define DTSM_BR_RBA_BASE   14'h3180
`define DTSM_IF_RAT_BASE   14'h2190
`define DTSM_BR_RAT_BASE   14'h3190
`define DTSM_REGION_STEP   14'h0200
`define DTSM_DEVPORT_TC_RD 6'h38
`define DTSM_DEVPORT_TC_WR 6'h39
`endif

//--- dtsm_pkg.sv
// Types for the debug trace address and map-space decode block.
// Assumes dtsm_defs.svh is compiled alongside.
package dtsm_pkg;
   typedef enum logic [2:0] {
      DTSM_IDLE = 3'b001,
      DTSM_MEM  = 3'b010,
      DTSM_MAP  = 3'b100
   } dtsm_state_t;
   // Map-space target select, index of decoded register
   typedef logic [5:0] dtsm_sel_t;
endpackage

//--- dtsm_range_match.sv
// One data trace range: 25-bit start and end, low-bit comparison.
// Assumes addresses arrive already truncated or not; it masks itself.
`timescale 1ns/1ps
`default_nettype none
`include "dtsm_defs.svh"
module dtsm_range_match #(
   parameter int AW = `DTSM_ADDR_W
) (
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic          load,
   input  wire logic [AW-1:0] start_in,
   input  wire logic [AW-1:0] end_in,
   input  wire logic          enable_in,
   input  wire logic [31:0]   addr,
   output logic               hit
);
   logic [AW-1:0] start_q;
   logic [AW-1:0] end_q;
   logic          en_q;

   // Range bounds hold only 25 bits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         start_q <= '0;
         end_q   <= '0;
         en_q    <= 1'b0;
      end else if (load) begin
         start_q <= start_in;
         end_q   <= end_in;
         en_q    <= enable_in;
      end
   end

   // Upper address bits ignored, so aliases match
   assign hit = en_q && (addr[AW-1:0] >= start_q) && (addr[AW-1:0] <= end_q);
endmodule
`default_nettype wire

//--- dtsm_top.sv
// Trace address truncation, range filter and map-space access decode.
// Assumes a same-clock core bus and message layer around it.
`timescale 1ns/1ps
`default_nettype none
`include "dtsm_defs.svh"
module dtsm_top #(
   parameter int AW = `DTSM_ADDR_W,
   parameter int MW = `DTSM_MAP_W
) (
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic          pt_valid,
   input  wire logic [31:0]   pt_addr,
   input  wire logic          dt_valid,
   input  wire logic [31:0]   dt_addr,
   input  wire logic          range_load,
   input  wire logic          range_sel,
   input  wire logic [AW-1:0] range_start,
   input  wire logic [AW-1:0] range_end,
   input  wire logic          range_enable,
   input  wire logic          rw_req,
   input  wire logic          rw_write,
   input  wire logic          rw_map,
   input  wire logic [31:0]   rw_addr,
   input  wire logic [9:0]    rw_spr_num,
   input  wire logic          rw_spr_valid,
   input  wire logic [5:0]    msg_tcode,
   input  wire logic          msg_valid,
   output logic               pt_out_valid,
   output logic [AW-1:0]      pt_out_addr,
   output logic               dt_out_valid,
   output logic [AW-1:0]      dt_out_addr,
   output logic               mem_req,
   output logic [AW-1:0]      mem_addr,
   output logic               map_req,
   output logic [MW-1:0]      map_addr,
   output logic               rw_refused,
   output logic               devport_req,
   output logic               devport_write
);
   logic [1:0]             range_hit;
   dtsm_pkg::dtsm_state_t  state_q;
   logic [MW-1:0]          map_d;
   logic                   map_ok;
   logic                   core_spr;

   // One matcher per data trace range
   for (genvar g = 0; g < 2; g++) begin : g_range
      dtsm_range_match #(.AW(AW)) u_range (
         .clk       (clk),
         .reset     (reset),
         .load      (range_load && (range_sel == 1'(g))),
         .start_in  (range_start),
         .end_in    (range_end),
         .enable_in (range_enable),
         .addr      (dt_addr),
         .hit       (range_hit[g])
      );
   end

   // Trace messages drop the upper 7 bits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pt_out_valid <= 1'b0;
         pt_out_addr  <= '0;
         dt_out_valid <= 1'b0;
         dt_out_addr  <= '0;
      end else begin
         pt_out_valid <= pt_valid;
         pt_out_addr  <= pt_addr[AW-1:0];
         dt_out_valid <= dt_valid && (|range_hit);
         dt_out_addr  <= dt_addr[AW-1:0];
      end
   end

   // Core-resident register numbers
   always_comb begin
      core_spr = 1'b0;
      case (rw_spr_num)
         10'd1, 10'd8, 10'd9, 10'd18, 10'd19, 10'd26, 10'd27,
         10'd80, 10'd81, 10'd82, 10'd287, 10'd1022: core_spr = 1'b1;
         default: core_spr = ((rw_spr_num >= 10'd144) && (rw_spr_num <= 10'd159))
                          || ((rw_spr_num >= 10'd272) && (rw_spr_num <= 10'd275));
      endcase
   end

   // Map-space decode of off-core registers
   always_comb begin
      map_d  = rw_addr[MW-1:0];
      map_ok = 1'b0;
      case (rw_addr[MW-1:0])
         `DTSM_DEC_ADDR:                          map_ok = 1'b1;
         `DTSM_TBL_RD_ADDR, `DTSM_TBH_RD_ADDR:    map_ok = !rw_write;
         `DTSM_TBL_WR_ADDR, `DTSM_TBH_WR_ADDR:    map_ok = rw_write;
         `DTSM_IF_GRA_ADDR, `DTSM_BR_GRA_ADDR:    map_ok = 1'b1;
         `DTSM_EXC_ADDR:                          map_ok = 1'b1;
         `DTSM_BB_CFG_ADDR, `DTSM_BR_CFG_ADDR:    map_ok = 1'b1;
         `DTSM_DPD_ADDR, `DTSM_IMM_ADDR:          map_ok = 1'b1;
         default: begin
            for (int i = 0; i < 4; i++) begin
               if (rw_addr[MW-1:0] == MW'(`DTSM_IF_RBA_BASE + i * `DTSM_REGION_STEP)
                || rw_addr[MW-1:0] == MW'(`DTSM_BR_RBA_BASE + i * `DTSM_REGION_STEP)
                || rw_addr[MW-1:0] == MW'(`DTSM_IF_RAT_BASE + i * `DTSM_REGION_STEP)
                || rw_addr[MW-1:0] == MW'(`DTSM_BR_RAT_BASE + i * `DTSM_REGION_STEP)) begin
                  map_ok = 1'b1;
               end
            end
         end
      endcase
      if (rw_spr_valid && core_spr) begin
         map_ok = 1'b0;
      end
   end

   // Access request routing
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q    <= dtsm_pkg::DTSM_IDLE;
         mem_req    <= 1'b0;
         mem_addr   <= '0;
         map_req    <= 1'b0;
         map_addr   <= '0;
         rw_refused <= 1'b0;
      end else begin
         mem_req    <= 1'b0;
         map_req    <= 1'b0;
         rw_refused <= 1'b0;
         state_q    <= dtsm_pkg::DTSM_IDLE;
         case (state_q)
            dtsm_pkg::DTSM_IDLE, dtsm_pkg::DTSM_MEM, dtsm_pkg::DTSM_MAP: begin
               if (rw_req && rw_map) begin
                  map_req    <= map_ok;
                  map_addr   <= map_d;
                  rw_refused <= !map_ok;
                  state_q    <= dtsm_pkg::DTSM_MAP;
               end else if (rw_req) begin
                  mem_req  <= 1'b1;
                  mem_addr <= rw_addr[AW-1:0];
                  state_q  <= dtsm_pkg::DTSM_MEM;
               end
            end
            default: state_q <= dtsm_pkg::DTSM_IDLE;
         endcase
      end
   end

   // Development port messages pass on codes 56 and 57
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         devport_req   <= 1'b0;
         devport_write <= 1'b0;
      end else begin
         devport_req   <= msg_valid && ((msg_tcode == `DTSM_DEVPORT_TC_RD)
                                     || (msg_tcode == `DTSM_DEVPORT_TC_WR));
         devport_write <= msg_valid && (msg_tcode == `DTSM_DEVPORT_TC_WR);
      end
   end

   trace_trunc_a: assert property (@(posedge clk) disable iff (reset)
      pt_valid |=> pt_out_valid && pt_out_addr == $past(pt_addr[AW-1:0]))
      else $error("program trace address not truncated");
   range_alias_a: assert property (@(posedge clk) disable iff (reset)
      dt_out_valid |-> $past(dt_valid && (|range_hit))
                       && dt_out_addr == $past(dt_addr[AW-1:0]))
      else $error("data trace passed outside range");
   map_route_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map |=> !mem_req && (map_req || rw_refused))
      else $error("map access reached memory");
   dec_decode_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && rw_addr[MW-1:0] == `DTSM_DEC_ADDR && !(rw_spr_valid && core_spr)
      |=> map_req && map_addr == `DTSM_DEC_ADDR)
      else $error("decrementer not decoded");
   tb_write_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && !rw_write
      && rw_addr[MW-1:0] inside {`DTSM_TBL_WR_ADDR, `DTSM_TBH_WR_ADDR} |=> rw_refused)
      else $error("timebase write address read");
   tb_read_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && rw_write
      && rw_addr[MW-1:0] inside {`DTSM_TBL_RD_ADDR, `DTSM_TBH_RD_ADDR} |=> rw_refused)
      else $error("timebase read address written");
   gra_decode_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && !(rw_spr_valid && core_spr)
      && rw_addr[MW-1:0] inside {`DTSM_IF_GRA_ADDR, `DTSM_BR_GRA_ADDR} |=> map_req)
      else $error("global region attribute not decoded");
   exc_decode_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && !(rw_spr_valid && core_spr)
      && rw_addr[MW-1:0] == `DTSM_EXC_ADDR |=> map_req)
      else $error("exception relocation base not decoded");
   cfg_decode_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && !(rw_spr_valid && core_spr)
      && rw_addr[MW-1:0] inside {`DTSM_BB_CFG_ADDR, `DTSM_BR_CFG_ADDR} |=> map_req)
      else $error("configuration register not decoded");
   dpd_decode_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && !(rw_spr_valid && core_spr)
      && rw_addr[MW-1:0] inside {`DTSM_DPD_ADDR, `DTSM_IMM_ADDR} |=> map_req)
      else $error("devport data or memory map not decoded");
   core_refuse_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && rw_spr_valid && core_spr |=> rw_refused && !map_req)
      else $error("core register reached through map");
   mem_trunc_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && !rw_map |=> mem_req && mem_addr == $past(rw_addr[AW-1:0]))
      else $error("memory access not truncated");
   devport_code_a: assert property (@(posedge clk) disable iff (reset)
      devport_req |-> $past(msg_tcode) inside {`DTSM_DEVPORT_TC_RD, `DTSM_DEVPORT_TC_WR})
      else $error("devport on wrong code");
   region_map_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && rw_addr[MW-1:0] == 14'h2780 && !rw_spr_valid |=> map_req)
      else $error("region base three not decoded");
   bridge_base_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && rw_addr[MW-1:0] == 14'h3780 && !rw_spr_valid |=> map_req)
      else $error("bridge region base three not decoded");
   ifetch_attr_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && rw_addr[MW-1:0] == 14'h2790 && !rw_spr_valid |=> map_req)
      else $error("ifetch region attribute three not decoded");
   bridge_attr_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && rw_addr[MW-1:0] == 14'h3790 && !rw_spr_valid |=> map_req)
      else $error("bridge region attribute three not decoded");
   unmapped_refuse_a: assert property (@(posedge clk) disable iff (reset)
      rw_req && rw_map && rw_addr[MW-1:0] == 14'h2000 |=> rw_refused && !map_req)
      else $error("unmapped register reached through map");
   devport_dir_a: assert property (@(posedge clk) disable iff (reset)
      msg_valid && msg_tcode inside {`DTSM_DEVPORT_TC_RD, `DTSM_DEVPORT_TC_WR}
      |=> devport_req && devport_write == $past(msg_tcode == `DTSM_DEVPORT_TC_WR))
      else $error("devport request or direction wrong");
endmodule
`default_nettype wire

//--- dtsm_tool_model.sv
// Debug tool model: drives access requests and message codes.
// Assumes the block samples on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module dtsm_tool_model (
   input  wire logic        clk,
   output logic             rw_req,
   output logic             rw_write,
   output logic             rw_map,
   output logic [31:0]      rw_addr,
   output logic [9:0]       rw_spr_num,
   output logic             rw_spr_valid,
   output logic [5:0]       msg_tcode,
   output logic             msg_valid
);
   logic core_halted;
   initial begin
      {rw_req, rw_write, rw_map, rw_spr_valid, msg_valid, core_halted} = '0;
      rw_addr = 32'h0;
      rw_spr_num = 10'h0;
      msg_tcode = 6'h0;
   end
   // One access cycle, address and register number inverted after release
   task automatic access(input logic wr, input logic mp, input logic [31:0] a,
                         input logic sv, input logic [9:0] sn);
      @(negedge clk);
      {rw_req, rw_write, rw_map, rw_addr, rw_spr_valid, rw_spr_num} = {1'b1, wr, mp, a, sv, sn};
      @(negedge clk);
      {rw_req, rw_spr_valid, rw_addr, rw_spr_num} = {1'b0, 1'b0, ~a, ~sn};
   endtask
   task automatic halt_core;
      core_halted = 1'b1;
   endtask
   // Message only once the core is halted
   task automatic send_msg(input logic [5:0] tc);
      if (core_halted) begin
         @(negedge clk);
         {msg_valid, msg_tcode} = {1'b1, tc};
         @(negedge clk);
         {msg_valid, msg_tcode} = {1'b0, ~tc};
      end
   endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the trace address and map-space decode block.
// Assumes the tool model beside it drives the access and message inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, reset = 1'b1, pt_valid = 1'b0, dt_valid = 1'b0;
   logic [31:0] pt_addr = 32'h0, dt_addr = 32'h0, rw_addr;
   logic range_load = 1'b0, range_sel = 1'b0, range_enable = 1'b0;
   logic [24:0] range_start = 25'h0, range_end = 25'h0, pt_out_addr, dt_out_addr, mem_addr;
   logic rw_req, rw_write, rw_map, rw_spr_valid, msg_valid, pt_out_valid, dt_out_valid;
   logic mem_req, map_req, rw_refused, devport_req, devport_write;
   logic [9:0] rw_spr_num;
   logic [5:0] msg_tcode;
   logic [13:0] map_addr;
   int n_fail = 0, total_checks = 0;
   always #10 clk = ~clk;
   dtsm_tool_model tool_u (.clk(clk), .rw_req(rw_req), .rw_write(rw_write), .rw_map(rw_map),
      .rw_addr(rw_addr), .rw_spr_num(rw_spr_num), .rw_spr_valid(rw_spr_valid),
      .msg_tcode(msg_tcode), .msg_valid(msg_valid));
   dtsm_top dut_u (.clk(clk), .reset(reset), .pt_valid(pt_valid), .pt_addr(pt_addr),
      .dt_valid(dt_valid), .dt_addr(dt_addr), .range_load(range_load), .range_sel(range_sel),
      .range_start(range_start), .range_end(range_end), .range_enable(range_enable),
      .rw_req(rw_req), .rw_write(rw_write), .rw_map(rw_map), .rw_addr(rw_addr),
      .rw_spr_num(rw_spr_num), .rw_spr_valid(rw_spr_valid), .msg_tcode(msg_tcode),
      .msg_valid(msg_valid), .pt_out_valid(pt_out_valid), .pt_out_addr(pt_out_addr),
      .dt_out_valid(dt_out_valid), .dt_out_addr(dt_out_addr), .mem_req(mem_req),
      .mem_addr(mem_addr), .map_req(map_req), .map_addr(map_addr), .rw_refused(rw_refused),
      .devport_req(devport_req), .devport_write(devport_write));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic map_try(input logic wr, input logic [13:0] a, input logic sv,
                          input logic [9:0] sn, input logic ok);
      tool_u.access(wr, 1'b1, {18'h0, a}, sv, sn);
      chk("map_req", 32'(ok), 32'(map_req));
      chk("rw_refused", 32'(!ok), 32'(rw_refused));
      chk("mem_req", 32'h0, 32'(mem_req));
      if (ok) chk("map_addr", 32'(a), 32'(map_addr));
   endtask
   task automatic dt_probe(input logic [31:0] a, input logic hit, input logic [24:0] exp);
      @(negedge clk);
      {dt_valid, dt_addr} = {1'b1, a};
      @(negedge clk);
      {dt_valid, dt_addr} = {1'b0, ~a};
      chk("dt_out_valid", 32'(hit), 32'(dt_out_valid));
      if (hit) chk("dt_out_addr", 32'(exp), 32'(dt_out_addr));
   endtask
   task automatic range_set(input logic sel, input logic [24:0] s, input logic [24:0] e,
                            input logic en);
      @(negedge clk);
      {range_load, range_sel, range_start, range_end, range_enable} = {2'b10 | sel, s, e, en};
      @(negedge clk);
      range_load = 1'b0;
   endtask
   task automatic test_trace;
      @(negedge clk);
      {pt_valid, pt_addr} = {1'b1, 32'hfe00_1234};
      @(negedge clk);
      {pt_valid, pt_addr} = {1'b0, 32'h01ff_edcb};
      chk("pt_out_valid", 32'h1, 32'(pt_out_valid));
      chk("pt_out_addr", 32'h0000_1234, 32'(pt_out_addr));
      $display("trace test done");
   endtask
   task automatic test_range;
      dt_probe(32'h01f0_0000, 1'b0, 25'h0);
      range_set(1'b0, 25'h1f0_0000, 25'h1f0_2000, 1'b1);
      range_set(1'b1, 25'h000_0100, 25'h000_0100, 1'b1);
      dt_probe(32'h03f0_0000, 1'b1, 25'h1f0_0000);
      dt_probe(32'hfff0_2000, 1'b1, 25'h1f0_2000);
      dt_probe(32'h01f0_2001, 1'b0, 25'h0);
      dt_probe(32'h01ef_ffff, 1'b0, 25'h0);
      dt_probe(32'hfe00_0100, 1'b1, 25'h000_0100);
      range_set(1'b1, 25'h000_0100, 25'h000_0100, 1'b0);
      dt_probe(32'h0000_0100, 1'b0, 25'h0);
      $display("range test done");
   endtask
   task automatic test_map;
      logic [13:0] fixed [8] = '{14'h2c00, 14'h2100, 14'h3100, 14'h2300,
                                 14'h2110, 14'h3110, 14'h2d30, 14'h3d30};
      int core [15] = '{1, 8, 9, 18, 19, 26, 27, 80, 82, 144, 159, 272, 275, 287, 1022};
      foreach (fixed[i]) map_try(i[0], fixed[i], 1'b0, 10'h0, 1'b1);
      for (int r = 0; r < 4; r++) begin
         map_try(r[0], 14'h2180 + 14'(r * 'h200), 1'b0, 10'h0, 1'b1);
         map_try(r[0], 14'h3180 + 14'(r * 'h200), 1'b0, 10'h0, 1'b1);
         map_try(!r[0], 14'h2190 + 14'(r * 'h200), 1'b0, 10'h0, 1'b1);
         map_try(!r[0], 14'h3190 + 14'(r * 'h200), 1'b0, 10'h0, 1'b1);
      end
      map_try(1'b0, 14'h1880, 1'b0, 10'h0, 1'b1);
      map_try(1'b0, 14'h1a80, 1'b0, 10'h0, 1'b1);
      map_try(1'b1, 14'h3880, 1'b0, 10'h0, 1'b1);
      map_try(1'b1, 14'h3a80, 1'b0, 10'h0, 1'b1);
      map_try(1'b1, 14'h1880, 1'b0, 10'h0, 1'b0);
      map_try(1'b0, 14'h3a80, 1'b0, 10'h0, 1'b0);
      map_try(1'b0, 14'h3880, 1'b0, 10'h0, 1'b0);
      map_try(1'b0, 14'h2000, 1'b0, 10'h0, 1'b0);
      map_try(1'b0, 14'h2c00, 1'b1, 10'd22, 1'b1);
      foreach (core[i]) map_try(1'b0, 14'h2c00, 1'b1, 10'(core[i]), 1'b0);
      $display("map test done");
   endtask
   task automatic test_mem_devport;
      tool_u.access(1'b0, 1'b0, 32'habcd_ef12, 1'b0, 10'h0);
      chk("mem_req", 32'h1, 32'(mem_req));
      chk("mem_addr", 32'h01cd_ef12, 32'(mem_addr));
      chk("map_req", 32'h0, 32'(map_req));
      tool_u.halt_core();
      for (int w = 0; w < 2; w++) begin
         tool_u.send_msg(6'h38 + 6'(w));
         chk("devport_req", 32'h1, 32'(devport_req));
         chk("devport_write", 32'(w), 32'(devport_write));
      end
      tool_u.send_msg(6'h37);
      chk("devport_req", 32'h0, 32'(devport_req));
      $display("memory and devport test done");
   endtask
   initial begin
      repeat (5) @(negedge clk);
      reset = 1'b0;
      test_trace();
      test_range();
      test_map();
      test_mem_devport();
      test_done();
   end
   initial begin
      #(20 * 3000);
      n_fail++;
      test_done();
   end
endmodule
`default_nettype wire
